// ===== src/mcc_regs.svh
`ifndef MCC_REGS_SVH
`define MCC_REGS_SVH

// Register indices; the byte address on the bus is four times the index
`define MCC_IDX_CTRL_A 6'h00
`define MCC_IDX_CTRL_B 6'h01
`define MCC_IDX_FREEZE 6'h02
`define MCC_IDX_STATE 6'h03
`define MCC_IDX_FAST_CTRL 6'h10
`define MCC_IDX_FAST_CTR 6'h11
`define MCC_IDX_FAST_SLOPE 6'h12
`define MCC_IDX_SLOW_CTRL 6'h18
`define MCC_IDX_ERR_BASE 6'h20

// Field positions
`define MCC_SYSTEM_CLOCK_OUTPUT_PIN_BIT 7
`define MCC_STBY_BIT 1
`define MCC_FUSE_LOCK_BIT 7
`define MCC_EXT_STABLE_BIT 7
`define MCC_SLOW_STABLE_BIT 5
`define MCC_FAST_STABLE_BIT 4

// Reset values
`define MCC_CTRL_B_RESET 8'h11

// Source select codes
`define MCC_SEL_FAST 2'h0
`define MCC_SEL_SLOW 2'h1
`define MCC_SEL_RSVD 2'h2
`define MCC_SEL_EXT 2'h3

// Source cycles counted before a clock gate opens
`define MCC_OSC_GATE_CYCLES 3'h4
`define MCC_EXT_GATE_CYCLES 3'h2

`endif

// ===== src/mcc_pkg.sv
package mcc_pkg;

    // Source switch sequencer
    typedef enum logic [0:0] {
        SW_IDLE,
        SW_WAIT
    } mcc_sw_t;

    // Source index: 0 fast, 1 slow, 2 external
    typedef logic [1:0] mcc_src_t;

endpackage

// ===== src/mcc_top.sv
// Overview of operation
// - Select field picks fast, slow or external source
// - Clock output bit drives clock onto pin
// - No pin clock in sleep unless used
// - Divider field sets prescaler ratio from table
// - Divider field changes at run time
// - Unprotected write is acked but changes nothing
// - All control and trim registers are protected
// - Slow oscillator also yields a 1 kHz tick
// - Slow output held four cycles after start-up
// - External request turns pin into clock input
// - External clock runs after two input cycles
// - Fuse picks 16 or 20 MHz and trims
// - Four signed frequency error bytes are readable
// - Error bytes: sign bit plus seven fraction bits
// - Prescaler off passes main clock undivided
// - Freeze bit locks controls until hardware reset
// - Pending flag reads one during source switch
// - Oscillator gate opens after four cycles; standby skips start-up
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "mcc_regs.svh"

module mcc_top
    import mcc_pkg::*;
#(
    parameter int SLOW_TO_1K_DIV = 32,
    parameter logic [5:0] CTR_TRIM_16M = 6'h20,
    parameter logic [5:0] CTR_TRIM_20M = 6'h20,
    parameter logic [3:0] SLOPE_TRIM_16M = 4'h8,
    parameter logic [3:0] SLOPE_TRIM_20M = 4'h8,
    parameter logic [7:0] ERR_16M_3V = 8'h00,
    parameter logic [7:0] ERR_16M_5V = 8'h00,
    parameter logic [7:0] ERR_20M_3V = 8'h00,
    parameter logic [7:0] ERR_20M_5V = 8'h00
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic o_wb_ack,
    output logic [31:0] o_wb_dat,
    input wire logic i_prot_window_open,
    input wire logic i_freq_20m_fuse,
    input wire logic i_cal_lock_fuse,
    input wire logic i_fast_osc_tick,
    input wire logic i_slow_osc_tick,
    input wire logic i_fast_analog_ready,
    input wire logic i_slow_analog_ready,
    input wire logic i_ext_clk_pin,
    input wire logic [2:0] i_periph_src_req,
    input wire logic i_sleep,
    input wire logic i_periph_uses_sysclk,
    output logic o_main_clk_en,
    output logic o_per_clk_en,
    output logic o_sysclk_out,
    output logic o_tick_1khz,
    output logic o_ext_pin_is_clock,
    output logic o_fast_osc_on,
    output logic o_slow_osc_on,
    output logic o_freq_20m,
    output logic [5:0] o_center_trim,
    output logic [3:0] o_slope_trim
);

    // Division ratio for a divider code; reserved codes divide by 2
    function automatic logic [6:0] div_ratio(input logic [3:0] code);
        case (code)
            4'h0: div_ratio = 7'h02;
            4'h1: div_ratio = 7'h04;
            4'h2: div_ratio = 7'h08;
            4'h3: div_ratio = 7'h10;
            4'h4: div_ratio = 7'h20;
            4'h5: div_ratio = 7'h40;
            4'h8: div_ratio = 7'h06;
            4'h9: div_ratio = 7'h0A;
            4'hA: div_ratio = 7'h0C;
            4'hB: div_ratio = 7'h18;
            4'hC: div_ratio = 7'h30;
            default: div_ratio = 7'h02;
        endcase
    endfunction

    logic ack_q;
    logic [31:0] rdat_q;
    logic system_clock_output_pin_en_q;
    logic [1:0] sel_req_q;
    mcc_src_t active_q;
    mcc_src_t target_q;
    mcc_sw_t sw_q;
    logic [3:0] div_q;
    logic pen_q;
    logic freeze_q;
    logic fast_stby_q;
    logic slow_stby_q;
    logic [5:0] ctr_trim_q;
    logic [3:0] slope_trim_q;
    logic fuse_lock_q;
    logic freq_20m_q;
    logic init_done_q;
    logic ext_s1_q;
    logic ext_s2_q;
    logic ext_s3_q;
    logic [2:0] gate_cnt_q [3];
    logic main_tick_q;
    logic per_en_q;
    logic [6:0] pcnt_q;
    logic system_clock_output_pin_q;
    logic [4:0] k1_cnt_q;
    logic tick_1k_q;
    logic ext_pin_q;

    // Bus request decode
    wire logic bus_req = i_wb_cyc && i_wb_stb && !ack_q;
    wire logic wr_en = bus_req && i_wb_we && i_wb_sel[0];
    wire logic [5:0] idx = i_wb_adr[7:2];
    wire logic [7:0] wd = i_wb_dat[7:0];
    wire logic is_ctrl_a = (idx == `MCC_IDX_CTRL_A);
    wire logic is_ctrl_b = (idx == `MCC_IDX_CTRL_B);
    wire logic is_freeze = (idx == `MCC_IDX_FREEZE);
    wire logic is_fast_ctrl = (idx == `MCC_IDX_FAST_CTRL);
    wire logic is_ctr = (idx == `MCC_IDX_FAST_CTR);
    wire logic is_slope = (idx == `MCC_IDX_FAST_SLOPE);
    wire logic is_slow_ctrl = (idx == `MCC_IDX_SLOW_CTRL);

    // Protected writes need the window; frozen registers refuse them
    wire logic prot_wr = wr_en && i_prot_window_open;
    wire logic main_wr_ok = prot_wr && !freeze_q;
    wire logic trim_locked = fuse_lock_q || (freeze_q && active_q == 2'h0);
    wire logic trim_wr_ok = prot_wr && !trim_locked;
    wire logic sel_wr = main_wr_ok && is_ctrl_a && sw_q == SW_IDLE
        && wd[1:0] != `MCC_SEL_RSVD && wd[1:0] != sel_req_q;

    // Source requests, start-up readiness, ticks and gate targets
    logic [2:0] src_req;
    logic [2:0] src_ready;
    logic [2:0] src_tick;
    logic [2:0] src_stable;
    logic [2:0] gate_need [3];
    assign src_req[0] = active_q == 2'h0 || (sw_q == SW_WAIT && target_q == 2'h0)
        || i_periph_src_req[0] || fast_stby_q;
    assign src_req[1] = active_q == 2'h1 || (sw_q == SW_WAIT && target_q == 2'h1)
        || i_periph_src_req[1] || slow_stby_q;
    assign src_req[2] = active_q == 2'h2 || (sw_q == SW_WAIT && target_q == 2'h2)
        || i_periph_src_req[2];
    assign src_ready[0] = i_fast_analog_ready || fast_stby_q;
    assign src_ready[1] = i_slow_analog_ready || slow_stby_q;
    assign src_ready[2] = 1'b1;
    assign src_tick[0] = i_fast_osc_tick;
    assign src_tick[1] = i_slow_osc_tick;
    assign src_tick[2] = ext_s2_q && !ext_s3_q && ext_pin_q;
    assign gate_need[0] = `MCC_OSC_GATE_CYCLES;
    assign gate_need[1] = `MCC_OSC_GATE_CYCLES;
    assign gate_need[2] = `MCC_EXT_GATE_CYCLES;
    assign src_stable[0] = (gate_cnt_q[0] == gate_need[0]);
    assign src_stable[1] = (gate_cnt_q[1] == gate_need[1]);
    assign src_stable[2] = (gate_cnt_q[2] == gate_need[2]);

    // Main clock comes from the active source only
    wire logic main_tick = src_tick[active_q] && src_stable[active_q];
    wire logic [6:0] ratio = div_ratio(div_q);

    // Register read mux; error bytes live above the control set
    logic [7:0] rd_mux;
    assign rd_mux =
        is_ctrl_a ? {system_clock_output_pin_en_q, 5'h00, sel_req_q} :
        is_ctrl_b ? {3'h0, div_q, pen_q} :
        is_freeze ? {7'h00, freeze_q} :
        (idx == `MCC_IDX_STATE) ? {src_stable[2], 1'b0, src_stable[1], src_stable[0],
            3'h0, sw_q == SW_WAIT} :
        is_fast_ctrl ? {6'h00, fast_stby_q, 1'b0} :
        is_ctr ? {2'h0, ctr_trim_q} :
        is_slope ? {fuse_lock_q, 3'h0, slope_trim_q} :
        is_slow_ctrl ? {6'h00, slow_stby_q, 1'b0} :
        (idx == `MCC_IDX_ERR_BASE) ? ERR_16M_3V :
        (idx == `MCC_IDX_ERR_BASE + 6'h01) ? ERR_16M_5V :
        (idx == `MCC_IDX_ERR_BASE + 6'h02) ? ERR_20M_3V :
        (idx == `MCC_IDX_ERR_BASE + 6'h03) ? ERR_20M_5V :
        8'h00;

    // Bus slave: one wait state, every address answered
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= bus_req;
            if (bus_req) begin
                rdat_q <= {24'h00_0000, rd_mux};
            end
        end
    end

    // Main control registers
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            system_clock_output_pin_en_q <= 1'b0;
            sel_req_q <= `MCC_SEL_FAST;
            div_q <= 4'(`MCC_CTRL_B_RESET >> 1);
            pen_q <= 1'b1;
            freeze_q <= 1'b0;
            fast_stby_q <= 1'b0;
            slow_stby_q <= 1'b0;
        end else begin
            if (main_wr_ok && is_ctrl_a) begin
                system_clock_output_pin_en_q <= wd[`MCC_SYSTEM_CLOCK_OUTPUT_PIN_BIT];
            end
            if (sel_wr) begin
                sel_req_q <= wd[1:0];
            end
            if (main_wr_ok && is_ctrl_b) begin
                div_q <= wd[4:1];
                pen_q <= wd[0];
            end
            if (main_wr_ok && is_freeze && wd[0]) begin
                freeze_q <= 1'b1;
            end
            if (prot_wr && is_fast_ctrl) begin
                fast_stby_q <= wd[`MCC_STBY_BIT];
            end
            if (prot_wr && is_slow_ctrl) begin
                slow_stby_q <= wd[`MCC_STBY_BIT];
            end
        end
    end

    // Fuse capture after reset release, then trim writes
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            init_done_q <= 1'b0;
            freq_20m_q <= 1'b0;
            fuse_lock_q <= 1'b0;
            ctr_trim_q <= 6'h00;
            slope_trim_q <= 4'h0;
        end else if (!init_done_q) begin
            init_done_q <= 1'b1;
            freq_20m_q <= i_freq_20m_fuse;
            fuse_lock_q <= i_cal_lock_fuse;
            ctr_trim_q <= i_freq_20m_fuse ? CTR_TRIM_20M : CTR_TRIM_16M;
            slope_trim_q <= i_freq_20m_fuse ? SLOPE_TRIM_20M : SLOPE_TRIM_16M;
        end else begin
            if (trim_wr_ok && is_ctr) begin
                ctr_trim_q <= wd[5:0];
            end
            if (trim_wr_ok && is_slope) begin
                slope_trim_q <= wd[3:0];
            end
        end
    end

    // Source switch sequencer
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sw_q <= SW_IDLE;
            active_q <= 2'h0;
            target_q <= 2'h0;
        end else begin
            case (sw_q)
                SW_IDLE: begin
                    if (sel_wr) begin
                        target_q <= (wd[1:0] == `MCC_SEL_EXT) ? 2'h2 : wd[1:0];
                        sw_q <= SW_WAIT;
                    end
                end
                SW_WAIT: begin
                    if (src_stable[target_q]) begin
                        active_q <= target_q;
                        sw_q <= SW_IDLE;
                    end
                end
                default: sw_q <= SW_IDLE;
            endcase
        end
    end

    // External pin synchroniser and pin function
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
            ext_pin_q <= 1'b0;
        end else begin
            ext_s1_q <= i_ext_clk_pin;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            ext_pin_q <= src_req[2];
        end
    end

    // Clock gates: count source cycles after start-up
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int i = 0; i < 3; i++) begin
                gate_cnt_q[i] <= 3'h0;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (!src_req[i]) begin
                    gate_cnt_q[i] <= 3'h0;
                end else if (src_ready[i] && src_tick[i] && gate_cnt_q[i] != gate_need[i]) begin
                    gate_cnt_q[i] <= gate_cnt_q[i] + 3'h1;
                end
            end
        end
    end

    // Prescaler; a shrunk ratio wraps at once
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            main_tick_q <= 1'b0;
            per_en_q <= 1'b0;
            pcnt_q <= 7'h00;
        end else begin
            main_tick_q <= main_tick;
            per_en_q <= 1'b0;
            if (main_tick) begin
                if (!pen_q) begin
                    per_en_q <= 1'b1;
                    pcnt_q <= 7'h00;
                end else if (pcnt_q >= ratio - 7'h01) begin
                    per_en_q <= 1'b1;
                    pcnt_q <= 7'h00;
                end else begin
                    pcnt_q <= pcnt_q + 7'h01;
                end
            end
        end
    end

    // Clock output pin toggles on each peripheral clock
    wire logic system_clock_output_pin_allowed = system_clock_output_pin_en_q && (!i_sleep || i_periph_uses_sysclk);
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            system_clock_output_pin_q <= 1'b0;
        end else if (!system_clock_output_pin_allowed) begin
            system_clock_output_pin_q <= 1'b0;
        end else if (per_en_q) begin
            system_clock_output_pin_q <= !system_clock_output_pin_q;
        end
    end

    // 1 kHz tick from the slow oscillator
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            k1_cnt_q <= 5'h00;
            tick_1k_q <= 1'b0;
        end else begin
            tick_1k_q <= 1'b0;
            if (i_slow_osc_tick && src_stable[1]) begin
                if (k1_cnt_q == 5'(SLOW_TO_1K_DIV - 1)) begin
                    k1_cnt_q <= 5'h00;
                    tick_1k_q <= 1'b1;
                end else begin
                    k1_cnt_q <= k1_cnt_q + 5'h01;
                end
            end
        end
    end

    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdat_q;
    assign o_main_clk_en = main_tick_q;
    assign o_per_clk_en = per_en_q;
    assign o_sysclk_out = system_clock_output_pin_q;
    assign o_tick_1khz = tick_1k_q;
    assign o_ext_pin_is_clock = ext_pin_q;
    assign o_fast_osc_on = src_req[0];
    assign o_slow_osc_on = src_req[1];
    assign o_freq_20m = freq_20m_q;
    assign o_center_trim = ctr_trim_q;
    assign o_slope_trim = slope_trim_q;

    // Checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    property p_unprot_ignored;
        wr_en && is_ctrl_b && !i_prot_window_open |=> $stable(div_q) && $stable(pen_q);
    endproperty
    a_unprot_ignored: assert property (p_unprot_ignored) else $error("unprotected write changed");

    property p_freeze_holds;
        freeze_q |=> freeze_q && $stable(system_clock_output_pin_en_q) && $stable(div_q);
    endproperty
    a_freeze_holds: assert property (p_freeze_holds) else $error("frozen state changed");

    property p_pen_off;
        main_tick && !pen_q |=> per_en_q;
    endproperty
    a_pen_off: assert property (p_pen_off) else $error("undivided clock missing");

    property p_div_wrap;
        main_tick && pen_q && pcnt_q == ratio - 7'h01 |=> per_en_q && pcnt_q == 7'h00;
    endproperty
    a_div_wrap: assert property (p_div_wrap) else $error("prescaler wrap wrong");

    property p_switch_done;
        sw_q == SW_WAIT && src_stable[target_q] |=> sw_q == SW_IDLE && active_q == $past(target_q);
    endproperty
    a_switch_done: assert property (p_switch_done) else $error("switch did not complete");

    property p_old_runs;
        sw_q == SW_WAIT && !src_stable[target_q] |=> $stable(active_q);
    endproperty
    a_old_runs: assert property (p_old_runs) else $error("source changed early");

    property p_sleep_quiet;
        i_sleep && !i_periph_uses_sysclk |=> !system_clock_output_pin_q;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("clock on pin in sleep");

    property p_ext_pin;
        src_req[2] |=> o_ext_pin_is_clock;
    endproperty
    a_ext_pin: assert property (p_ext_pin) else $error("pin not turned to clock");

    property p_gate_off;
        !src_req[1] |=> !src_stable[1];
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("gate open without request");

    property p_tick_1k;
        tick_1k_q |=> !tick_1k_q;
    endproperty
    a_tick_1k: assert property (p_tick_1k) else $error("1 kHz tick too long");

    c_switch: cover property (sw_q == SW_WAIT ##1 sw_q == SW_IDLE);
    c_freeze: cover property ($rose(freeze_q));
    c_ext_stable: cover property ($rose(src_stable[2]));
    c_div_pulse: cover property (pen_q && per_en_q);

endmodule

`default_nettype wire

// ===== verif/mcc_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "mcc_regs.svh"

module mcc_tb_top;
    localparam int TIMEOUT = 40000;

    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_wb_cyc = 1'b0;
    logic i_wb_stb = 1'b0;
    logic i_wb_we = 1'b0;
    logic [7:0] i_wb_adr = 8'h00;
    logic [3:0] i_wb_sel = 4'h0;
    logic [31:0] i_wb_dat = 32'h0000_0000;
    logic i_prot_window_open = 1'b0;
    logic i_freq_20m_fuse = 1'b1;
    logic i_cal_lock_fuse = 1'b0;
    logic i_fast_analog_ready = 1'b1;
    logic i_slow_analog_ready = 1'b1;
    logic i_fast_osc_tick = 1'b0;
    logic i_slow_osc_tick = 1'b0;
    logic i_ext_clk_pin = 1'b0;
    logic [2:0] i_periph_src_req = 3'h1;
    logic i_sleep = 1'b0;
    logic i_periph_uses_sysclk = 1'b0;
    logic [1:0] slow_cnt = 2'h0;
    logic [2:0] ext_cnt = 3'h0;
    wire logic o_wb_ack;
    wire logic [31:0] o_wb_dat;
    wire logic o_main_clk_en;
    wire logic o_per_clk_en;
    wire logic o_sysclk_out;
    wire logic o_tick_1khz;
    wire logic o_ext_pin_is_clock;
    wire logic o_fast_osc_on;
    wire logic o_slow_osc_on;
    wire logic o_freq_20m;
    wire logic [5:0] o_center_trim;
    wire logic [3:0] o_slope_trim;
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;
    int n;
    int k;
    logic [3:0] codes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC};
    int ratios [11] = '{2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48};
    logic [5:0] prot_idx [7] = '{6'h00, 6'h01, 6'h02, 6'h10, 6'h11, 6'h12, 6'h18};
    logic [7:0] prot_rst [7] = '{8'h00, 8'h11, 8'h00, 8'h00, 8'h2A, 8'h05, 8'h00};
    logic [7:0] err_val [4] = '{8'h81, 8'h00, 8'h00, 8'h05};

    mcc_top #(
        .CTR_TRIM_16M(6'h15), .CTR_TRIM_20M(6'h2A), .SLOPE_TRIM_20M(4'h5),
        .ERR_16M_3V(8'h81), .ERR_20M_5V(8'h05)
    ) u_mcc_top (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
        .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
        .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat), .i_prot_window_open(i_prot_window_open),
        .i_freq_20m_fuse(i_freq_20m_fuse), .i_cal_lock_fuse(i_cal_lock_fuse),
        .i_fast_osc_tick(i_fast_osc_tick), .i_slow_osc_tick(i_slow_osc_tick),
        .i_fast_analog_ready(i_fast_analog_ready),
        .i_slow_analog_ready(i_slow_analog_ready), .i_ext_clk_pin(i_ext_clk_pin),
        .i_periph_src_req(i_periph_src_req), .i_sleep(i_sleep),
        .i_periph_uses_sysclk(i_periph_uses_sysclk), .o_main_clk_en(o_main_clk_en),
        .o_per_clk_en(o_per_clk_en), .o_sysclk_out(o_sysclk_out), .o_tick_1khz(o_tick_1khz),
        .o_ext_pin_is_clock(o_ext_pin_is_clock), .o_fast_osc_on(o_fast_osc_on),
        .o_slow_osc_on(o_slow_osc_on), .o_freq_20m(o_freq_20m),
        .o_center_trim(o_center_trim), .o_slope_trim(o_slope_trim)
    );

    // Clock, 100 MHz
    always #5 i_clk = ~i_clk;

    // Oscillator ticks: fast every cycle, slow every 4, external pin period 6
    always @(posedge i_clk) begin
        slow_cnt <= slow_cnt + 2'h1;
        ext_cnt <= (ext_cnt == 3'h5) ? 3'h0 : ext_cnt + 3'h1;
        i_fast_osc_tick <= 1'b1;
        i_slow_osc_tick <= (slow_cnt == 2'h3);
        i_ext_clk_pin <= (ext_cnt < 3'h3);
    end

    // Hang guard
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic end_of_test;
        if (n_fail == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One classic Wishbone cycle; ack and data are taken at the sampling edge
    task automatic wb_xfer(input logic we, input logic [5:0] idx, input logic [7:0] data,
                           input logic win, output logic [31:0] rdata);
        int w;
        w = 0;
        @(posedge i_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= we;
        i_wb_adr <= {idx, 2'b00};
        i_wb_dat <= {24'h00_0000, data};
        i_wb_sel <= 4'hF;
        i_prot_window_open <= win;
        do begin
            @(posedge i_clk);
            w++;
        end while (o_wb_ack !== 1'b1 && w < 50);
        rdata = o_wb_dat;
        if (w >= 50) begin
            check(32'h0000_0000, 32'h0000_0001);
        end
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        i_wb_we <= 1'b0;
        i_prot_window_open <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] data, input logic win);
        logic [31:0] unused;
        wb_xfer(1'b1, idx, data, win, unused);
    endtask

    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        wb_xfer(1'b0, idx, 8'h00, 1'b0, d);
        check(d, {24'h00_0000, exp});
    endtask

    // Spacing of pulses; the third count is a clean period after any change
    task automatic period_chk(input logic which, input int exp);
        int c;
        int p;
        c = 0;
        for (p = 0; p < 3; p++) begin
            c = 0;
            do begin
                @(posedge i_clk);
                c++;
            end while ((which ? o_tick_1khz : o_per_clk_en) !== 1'b1 && c < 300);
        end
        check(c, exp);
    endtask

    // Changes of the clock pin over 40 cycles
    task automatic toggles(output int t);
        logic last;
        int c;
        t = 0;
        repeat (3) @(posedge i_clk);
        last = o_sysclk_out;
        for (c = 0; c < 40; c++) begin
            @(posedge i_clk);
            if (o_sysclk_out !== last) t++;
            last = o_sysclk_out;
        end
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (2) @(posedge i_clk);
        check(o_freq_20m, 1'b1);
        check(o_center_trim, 6'h2A);
        check(o_slope_trim, 4'h5);
        check(o_fast_osc_on, 1'b1);
        check(o_slow_osc_on, 1'b0);
        period_chk(1'b0, 6);
        for (k = 0; k < 4; k++) begin
            rd_chk(6'(`MCC_IDX_ERR_BASE + k), err_val[k]);
        end
        rd_chk(6'h05, 8'h00);
        // Writes without the window are acked and ignored
        for (k = 0; k < 7; k++) begin
            wr(prot_idx[k], 8'hFF, 1'b0);
            rd_chk(prot_idx[k], prot_rst[k]);
        end
        wr(`MCC_IDX_FAST_CTR, 8'h33, 1'b1);
        rd_chk(`MCC_IDX_FAST_CTR, 8'h33);
        check(o_center_trim, 6'h33);
        wr(`MCC_IDX_FAST_SLOPE, 8'h0C, 1'b1);
        check(o_slope_trim, 4'hC);
        // Every non-reserved divider code changed while running
        for (k = 0; k < 11; k++) begin
            wr(`MCC_IDX_CTRL_B, {3'h0, codes[k], 1'b1}, 1'b1);
            period_chk(1'b0, ratios[k]);
        end
        wr(`MCC_IDX_CTRL_B, 8'h18, 1'b1);
        period_chk(1'b0, 1);
        // Clock pin at divide by 2, then sleep
        wr(`MCC_IDX_CTRL_B, 8'h01, 1'b1);
        wr(`MCC_IDX_CTRL_A, 8'h80, 1'b1);
        toggles(n);
        check(n, 20);
        @(posedge i_clk);
        i_sleep <= 1'b1;
        toggles(n);
        check(n, 0);
        check(o_sysclk_out, 1'b0);
        @(posedge i_clk);
        i_periph_uses_sysclk <= 1'b1;
        toggles(n);
        check(n, 20);
        @(posedge i_clk);
        i_sleep <= 1'b0;
        i_periph_uses_sysclk <= 1'b0;
        wr(`MCC_IDX_CTRL_A, 8'h82, 1'b1);
        rd_chk(`MCC_IDX_CTRL_A, 8'h80);
        // Switch to the slow source
        wr(`MCC_IDX_CTRL_B, 8'h00, 1'b1);
        wr(`MCC_IDX_CTRL_A, 8'h81, 1'b1);
        rd_chk(`MCC_IDX_STATE, 8'h11);
        repeat (60) @(posedge i_clk);
        rd_chk(`MCC_IDX_STATE, 8'h30);
        check(o_slow_osc_on, 1'b1);
        rd_chk(`MCC_IDX_CTRL_A, 8'h81);
        period_chk(1'b0, 4);
        period_chk(1'b1, 128);
        // Main clock enable once per slow tick
        n = 0;
        repeat (40) begin
            @(posedge i_clk);
            if (o_main_clk_en === 1'b1) n++;
        end
        check(n, 10);
        // External pin requested by a peripheral, then selected
        @(posedge i_clk);
        i_periph_src_req <= 3'h5;
        repeat (10) @(posedge i_clk);
        check(o_ext_pin_is_clock, 1'b1);
        wr(`MCC_IDX_CTRL_A, 8'h83, 1'b1);
        repeat (60) @(posedge i_clk);
        rd_chk(`MCC_IDX_STATE, 8'h90);
        period_chk(1'b0, 6);
        wr(`MCC_IDX_CTRL_A, 8'h80, 1'b1);
        repeat (20) @(posedge i_clk);
        period_chk(1'b0, 1);
        // Freeze: controls and active trims stay, standby bit still writable
        wr(`MCC_IDX_FREEZE, 8'h01, 1'b1);
        rd_chk(`MCC_IDX_FREEZE, 8'h01);
        wr(`MCC_IDX_CTRL_B, 8'h11, 1'b1);
        rd_chk(`MCC_IDX_CTRL_B, 8'h00);
        wr(`MCC_IDX_FAST_CTR, 8'h10, 1'b1);
        rd_chk(`MCC_IDX_FAST_CTR, 8'h33);
        wr(`MCC_IDX_FAST_CTRL, 8'h02, 1'b1);
        rd_chk(`MCC_IDX_FAST_CTRL, 8'h02);
        // Second reset: 16 MHz fuse, trims locked by fuse, oscillators not ready
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        i_freq_20m_fuse <= 1'b0;
        i_cal_lock_fuse <= 1'b1;
        i_fast_analog_ready <= 1'b0;
        i_slow_analog_ready <= 1'b0;
        i_periph_src_req <= 3'h3;
        repeat (3) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (2) @(posedge i_clk);
        check(o_freq_20m, 1'b0);
        check(o_center_trim, 6'h15);
        rd_chk(`MCC_IDX_FREEZE, 8'h00);
        wr(`MCC_IDX_FAST_CTR, 8'h11, 1'b1);
        rd_chk(`MCC_IDX_FAST_CTR, 8'h15);
        rd_chk(`MCC_IDX_FAST_SLOPE, 8'h88);
        repeat (40) @(posedge i_clk);
        rd_chk(`MCC_IDX_STATE, 8'h00);
        // Standby bits stand in for the missing analog start-up
        wr(`MCC_IDX_FAST_CTRL, 8'h02, 1'b1);
        wr(`MCC_IDX_SLOW_CTRL, 8'h02, 1'b1);
        repeat (40) @(posedge i_clk);
        rd_chk(`MCC_IDX_STATE, 8'h30);
        period_chk(1'b0, 6);
        end_of_test();
    end
endmodule

`default_nettype wire
